//--- rtl/ctu_consts.vh
/*
 * Constants for the control transfer unit: operation codes, vector
 * numbers, bus cycle length, queue size and register map offsets.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef CTU_CONSTS_VH
`define CTU_CONSTS_VH

// Operation codes written to the command register
`define OP_LOOP 5'h01
`define OP_LOOP_EQ 5'h02
`define OP_LOOP_NE 5'h03
`define OP_JCZ 5'h04
`define OP_INT 5'h05
`define OP_INT3 5'h06
`define OP_INTO 5'h07
`define OP_INT_RETURN 5'h08
`define OP_CLEAR_CARRY 5'h09
`define OP_FLIP_CARRY 5'h0A
`define OP_SET_CARRY 5'h0B
`define OP_CLEAR_DIR 5'h0C
`define OP_CLEAR_INT_ENABLE 5'h0D
`define OP_SET_INT_ENABLE 5'h0E
`define OP_HALT 5'h0F
`define OP_WAIT 5'h10
`define OP_ESCAPE 5'h11
`define OP_NOP 5'h12

// Vector types
`define VEC_STEP 8'h01
`define VEC_NMI 8'h02
`define VEC_BRK 8'h03
`define VEC_OVF 8'h04

// Flag bit positions in the 16-bit flag image
`define FB_CARRY 0
`define FB_ZERO 6
`define FB_TRAP 8
`define FB_IF 9
`define FB_DIR 10
`define FB_OVF 11

// Bus timing
`define BUS_CLKS 3'h4
`define QUEUE_BYTES 3'h4

// Register byte offsets
`define A_CMD 12'h000
`define A_FLAGS 12'h004
`define A_COUNT 12'h008
`define A_STATUS 12'h00C
`define A_IP 12'h010
`define A_CS 12'h014
`define A_SP 12'h018
`define A_EA 12'h01C
`define A_LAST 12'h020

`define FLAGS_RST 16'h0002
`define SP_RST 16'h0400

`endif

//--- rtl/cpu_control_transfer_unit.v
/*
 * Control transfer unit: executes loop, interrupt, flag, halt, wait,
 * escape and lock operations issued over APB, and runs the stack and
 * vector-table byte transfers on a private memory port.
 * Assumes a synchronous memory that answers each request with mem_ack_in
 * held for one cycle, and APB inputs synchronous to ref_clk_in.
 */
// Chosen here: the APB register port and the register offsets.
// Operation
// (RULE1) Plain loop: count minus one, branch if result nonzero
// (RULE2) Loop-while-equal: decrement, branch if nonzero count and zero flag set
// (RULE3) Loop-while-not-equal: decrement, branch if nonzero count and zero flag clear
// (RULE4) Jump-if-count-zero branches on zero count, count untouched
// (RULE5) Interrupts push flags then far-call via four-byte vector at type*4
// (RULE6) Software interrupt clears trap and enable flags; short form selects type 3
// (RULE7) Trap-on-overflow uses vector 4 only when overflow flag set
// (RULE8) Interrupt return pops offset, segment and flag image
// (RULE9) Clear, complement, set carry; clear direction
// (RULE10) Clear-enable masks maskable interrupts, non-maskable still taken
// (RULE11) Set-enable takes effect after the following instruction completes
// (RULE12) Halt stops until reset, enabled interrupt or non-maskable interrupt
// (RULE13) Wait idles while test is low; interrupt saves wait's own address
// (RULE14) Leaving wait blocks external interrupts for one more instruction; here only maskable requests are blocked, not NMI
// (RULE15) Escape only performs its memory operand access
// (RULE16) Lock prefix holds bus lock for the whole instruction
// (RULE17) Trap flag set raises a type 1 interrupt after each instruction
// (RULE18) Trap flag cleared only after flags are pushed
// (RULE19) Instruction clearing trap flag still gets its step interrupt
// (RULE20) Step sequence follows other interrupt sequence, before handler runs; here for software interrupts only, external ones follow it
// (RULE21) Every memory byte reference takes four clocks
// (RULE22) Four-byte queue; operand request waits at most one clock
`timescale 1ns/1ps
`include "ctu_consts.vh"

module cpu_control_transfer_unit #(
    parameter QDEPTH = 4
) (
    input wire ref_clk_in, // 250 MHz clock
    input wire rstn_in, // Async reset, active low
    input wire clk_en_in, // Freezes all state when low
    input wire psel_in, // APB select
    input wire penable_in, // APB enable
    input wire pwrite_in, // APB direction
    input wire [11:0] paddr_in, // APB byte address
    input wire [31:0] pwdata_in, // APB write data
    output reg [31:0] prdata_out, // APB read data
    output reg pready_out, // APB ready
    output reg pslverr_out, // APB error
    input wire intr_in, // Maskable interrupt request level
    input wire [7:0] intr_type_in, // Type of maskable request
    input wire nmi_in, // Non-maskable request, taken on rising edge
    input wire test_in, // Wait release input
    output reg intr_ack_out, // Maskable request taken, one cycle
    output reg nmi_ack_out, // Non-maskable taken, one cycle
    output reg mem_req_out, // Memory byte request level
    output reg mem_we_out, // Memory write
    output reg [19:0] mem_addr_out, // Memory byte address
    output reg [7:0] mem_wdata_out, // Memory write byte
    input wire [7:0] mem_rdata_in, // Memory read byte
    input wire mem_ack_in, // Memory transfer done
    output reg bus_lock_out, // Bus lock
    output reg halted_out, // Halt state
    output reg waiting_out // Wait state
);
    // ****************************************
    // States
    // ****************************************
    localparam S_IDLE = 4'h0;
    localparam S_EXEC = 4'h1;
    localparam S_PUSH = 4'h2;
    localparam S_VEC = 4'h3;
    localparam S_POP = 4'h4;
    localparam S_HALT = 4'h5;
    localparam S_WAIT = 4'h6;
    localparam S_ESC = 4'h7;
    localparam S_CHECK = 4'h8;

    reg [3:0] state_reg;
    reg [15:0] flags_reg;
    reg [15:0] count_register_reg;
    reg [15:0] ip_reg;
    reg [15:0] cs_reg;
    reg [15:0] sp_reg;
    reg [19:0] ea_reg;
    reg [4:0] op_reg;
    reg [7:0] imm_reg;
    reg lock_reg;
    reg busy_reg;
    reg [7:0] vtype_reg;
    reg [2:0] idx_reg;
    reg [2:0] clk_cnt_reg;
    reg [7:0] byte_reg [0:5];
    reg [15:0] wait_ip_reg;
    reg ie_shadow_reg;
    reg int_block_reg;
    reg step_pend_reg;
    reg nmi_prev_reg;
    reg nmi_pend_reg;
    reg [7:0] last_reg;
    reg [2:0] qfill_reg;
    reg stall_reg;
    reg [15:0] ret_ip_reg;
    integer i;

    wire wr_acc = psel_in & penable_in & pwrite_in & pready_out;
    wire rd_acc = psel_in & penable_in & ~pwrite_in & pready_out;
    wire [15:0] cnt_dec = count_register_reg - 16'h0001;
    wire zero_flag = flags_reg[`FB_ZERO];
    wire [19:0] stack_base = {cs_reg, 4'h0};
    wire maskable_ok = intr_in & flags_reg[`FB_IF] & ~ie_shadow_reg & ~int_block_reg; // RULE10
    wire [19:0] vec_addr = {10'h000, vtype_reg, 2'b00} + {17'h00000, idx_reg}; // RULE5
    wire [19:0] push_addr = stack_base + {4'h0, sp_reg} - {17'h00000, idx_reg} - 20'h00001;
    wire [19:0] pop_addr = stack_base + {4'h0, sp_reg} + {17'h00000, idx_reg};

    // Push order: flags high/low, segment high/low, offset high/low
    reg [7:0] push_byte;
    always @* begin
        case (idx_reg)
            3'h0: push_byte = flags_reg[15:8];
            3'h1: push_byte = flags_reg[7:0];
            3'h2: push_byte = cs_reg[15:8];
            3'h3: push_byte = cs_reg[7:0];
            3'h4: push_byte = ret_ip_reg[15:8];
            default: push_byte = ret_ip_reg[7:0];
        endcase
    end

    // ****************************************
    // Register bus
    // ****************************************
    always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h00000000;
        end else if (clk_en_in) begin
            // One wait state: setup, access, then ready
            pready_out <= psel_in & penable_in & ~pready_out;
            pslverr_out <= 1'b0;
            if (psel_in & penable_in & ~pready_out) begin
                pslverr_out <= paddr_in > `A_LAST;
                case (paddr_in)
                    `A_CMD: prdata_out <= {18'h00000, lock_reg, imm_reg, op_reg};
                    `A_FLAGS: prdata_out <= {16'h0000, flags_reg};
                    `A_COUNT: prdata_out <= {16'h0000, count_register_reg};
                    `A_STATUS: prdata_out <= {24'h000000, qfill_reg, stall_reg,
                        state_reg};
                    `A_IP: prdata_out <= {16'h0000, ip_reg};
                    `A_CS: prdata_out <= {16'h0000, cs_reg};
                    `A_SP: prdata_out <= {16'h0000, sp_reg};
                    `A_EA: prdata_out <= {12'h000, ea_reg};
                    `A_LAST: prdata_out <= {24'h000000, last_reg};
                    default: prdata_out <= 32'h00000000;
                endcase
            end
        end
    end

    // ****************************************
    // Execution engine
    // ****************************************
    always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg <= S_IDLE;
            flags_reg <= `FLAGS_RST;
            count_register_reg <= 16'h0000;
            ip_reg <= 16'h0000;
            cs_reg <= 16'h0000;
            sp_reg <= `SP_RST;
            ea_reg <= 20'h00000;
            op_reg <= 5'h00;
            imm_reg <= 8'h00;
            lock_reg <= 1'b0;
            busy_reg <= 1'b0;
            vtype_reg <= 8'h00;
            idx_reg <= 3'h0;
            clk_cnt_reg <= 3'h0;
            for (i = 0; i < 6; i = i + 1)
                byte_reg[i] <= 8'h00;
            wait_ip_reg <= 16'h0000;
            ie_shadow_reg <= 1'b0;
            int_block_reg <= 1'b0;
            step_pend_reg <= 1'b0;
            nmi_prev_reg <= 1'b0;
            nmi_pend_reg <= 1'b0;
            last_reg <= 8'h00;
            qfill_reg <= 3'h0;
            stall_reg <= 1'b0;
            ret_ip_reg <= 16'h0000;
            intr_ack_out <= 1'b0;
            nmi_ack_out <= 1'b0;
            mem_req_out <= 1'b0;
            mem_we_out <= 1'b0;
            mem_addr_out <= 20'h00000;
            mem_wdata_out <= 8'h00;
            bus_lock_out <= 1'b0;
            halted_out <= 1'b0;
            waiting_out <= 1'b0;
        end else if (clk_en_in) begin
            intr_ack_out <= 1'b0;
            nmi_ack_out <= 1'b0;
            nmi_prev_reg <= nmi_in;
            // Edge request survives until taken; a new edge wins over the take
            if (nmi_in & ~nmi_prev_reg)
                nmi_pend_reg <= 1'b1;
            // Idle-time prefetch fills the queue while no operation runs
            if (state_reg == S_IDLE && qfill_reg < `QUEUE_BYTES) // RULE22
                qfill_reg <= qfill_reg + 3'h1;
            if (wr_acc && paddr_in != `A_CMD) begin
                case (paddr_in)
                    `A_FLAGS: flags_reg <= pwdata_in[15:0];
                    `A_COUNT: count_register_reg <= pwdata_in[15:0];
                    `A_IP: ip_reg <= pwdata_in[15:0];
                    `A_CS: cs_reg <= pwdata_in[15:0];
                    `A_SP: sp_reg <= pwdata_in[15:0];
                    `A_EA: ea_reg <= pwdata_in[19:0];
                    default: last_reg <= last_reg;
                endcase
            end
            case (state_reg)
                S_IDLE: begin
                    if (wr_acc && paddr_in == `A_CMD) begin
                        op_reg <= pwdata_in[4:0];
                        imm_reg <= pwdata_in[12:5];
                        lock_reg <= pwdata_in[13];
                        bus_lock_out <= pwdata_in[13]; // RULE16
                        busy_reg <= 1'b1;
                        // Trap state latched at start, so clearing it inside
                        // the instruction still yields the step trap
                        step_pend_reg <= flags_reg[`FB_TRAP]; // RULE17 RULE19
                        ip_reg <= ip_reg + 16'h0001;
                        ret_ip_reg <= ip_reg + 16'h0001;
                        wait_ip_reg <= ip_reg;
                        state_reg <= S_EXEC;
                    end else if (nmi_pend_reg) begin
                        nmi_pend_reg <= nmi_in & ~nmi_prev_reg;
                        nmi_ack_out <= 1'b1;
                        vtype_reg <= `VEC_NMI;
                        ret_ip_reg <= ip_reg;
                        idx_reg <= 3'h0;
                        state_reg <= S_PUSH;
                    end else if (maskable_ok) begin
                        intr_ack_out <= 1'b1;
                        vtype_reg <= intr_type_in;
                        ret_ip_reg <= ip_reg;
                        idx_reg <= 3'h0;
                        state_reg <= S_PUSH;
                    end
                end
                S_EXEC: begin
                    state_reg <= S_CHECK;
                    case (op_reg)
                        `OP_LOOP: begin
                            count_register_reg <= cnt_dec;
                            if (cnt_dec != 16'h0000) // RULE1
                                ip_reg <= ip_reg + {{8{imm_reg[7]}}, imm_reg};
                        end
                        `OP_LOOP_EQ: begin
                            count_register_reg <= cnt_dec;
                            if (cnt_dec != 16'h0000 && zero_flag) // RULE2
                                ip_reg <= ip_reg + {{8{imm_reg[7]}}, imm_reg};
                        end
                        `OP_LOOP_NE: begin
                            count_register_reg <= cnt_dec;
                            if (cnt_dec != 16'h0000 && !zero_flag) // RULE3
                                ip_reg <= ip_reg + {{8{imm_reg[7]}}, imm_reg};
                        end
                        `OP_JCZ: begin
                            if (count_register_reg == 16'h0000) // RULE4
                                ip_reg <= ip_reg + {{8{imm_reg[7]}}, imm_reg};
                        end
                        `OP_INT, `OP_INT3: begin
                            vtype_reg <= (op_reg == `OP_INT3) ? `VEC_BRK : imm_reg; // RULE6
                            idx_reg <= 3'h0;
                            state_reg <= S_PUSH;
                        end
                        `OP_INTO: begin
                            if (flags_reg[`FB_OVF]) begin // RULE7
                                vtype_reg <= `VEC_OVF;
                                idx_reg <= 3'h0;
                                state_reg <= S_PUSH;
                            end
                        end
                        `OP_INT_RETURN: begin
                            idx_reg <= 3'h0;
                            state_reg <= S_POP; // RULE8
                        end
                        `OP_CLEAR_CARRY: flags_reg[`FB_CARRY] <= 1'b0; // RULE9
                        `OP_FLIP_CARRY: flags_reg[`FB_CARRY] <= ~flags_reg[`FB_CARRY]; // RULE9
                        `OP_SET_CARRY: flags_reg[`FB_CARRY] <= 1'b1; // RULE9
                        `OP_CLEAR_DIR: flags_reg[`FB_DIR] <= 1'b0; // RULE9
                        `OP_CLEAR_INT_ENABLE: flags_reg[`FB_IF] <= 1'b0; // RULE10
                        `OP_SET_INT_ENABLE: flags_reg[`FB_IF] <= 1'b1;
                        `OP_HALT: begin
                            halted_out <= 1'b1;
                            state_reg <= S_HALT; // RULE12
                        end
                        `OP_WAIT: begin
                            if (!test_in) begin
                                waiting_out <= 1'b1;
                                state_reg <= S_WAIT; // RULE13
                            end
                        end
                        `OP_ESCAPE: begin
                            idx_reg <= 3'h0;
                            state_reg <= S_ESC; // RULE15
                        end
                        default: state_reg <= S_CHECK;
                    endcase
                end
                S_HALT: begin
                    if (nmi_pend_reg || maskable_ok) begin // RULE12
                        halted_out <= 1'b0;
                        state_reg <= S_CHECK;
                    end
                end
                S_WAIT: begin
                    if (test_in) begin
                        waiting_out <= 1'b0;
                        state_reg <= S_CHECK;
                    end else if (nmi_pend_reg || maskable_ok) begin
                        // Return lands on the wait itself so it is re-entered
                        waiting_out <= 1'b0;
                        ip_reg <= wait_ip_reg; // RULE13
                        state_reg <= S_CHECK;
                    end
                end
                S_PUSH, S_VEC, S_POP, S_ESC: begin
                    // Each byte reference runs at least four clocks, ending on mem_ack_in
                    if (!mem_req_out && !stall_reg && qfill_reg == 3'h0) begin
                        // A fetch already started costs one clock
                        stall_reg <= 1'b1; // RULE22
                    end else if (!mem_req_out) begin
                        stall_reg <= 1'b0;
                        mem_req_out <= 1'b1;
                        clk_cnt_reg <= 3'h1;
                        mem_we_out <= state_reg == S_PUSH;
                        mem_wdata_out <= push_byte;
                        mem_addr_out <= (state_reg == S_PUSH) ? push_addr :
                            (state_reg == S_VEC) ? vec_addr :
                            (state_reg == S_POP) ? pop_addr : ea_reg;
                    end else begin
                        if (clk_cnt_reg < `BUS_CLKS) // RULE21
                            clk_cnt_reg <= clk_cnt_reg + 3'h1;
                        if (mem_ack_in && clk_cnt_reg >= `BUS_CLKS - 3'h1) begin
                            mem_req_out <= 1'b0;
                            byte_reg[idx_reg] <= mem_rdata_in;
                            idx_reg <= idx_reg + 3'h1;
                            if (!mem_we_out) last_reg <= mem_rdata_in;
                            if (state_reg == S_PUSH && idx_reg == 3'h5) begin
                                sp_reg <= sp_reg - 16'h0006;
                                // Trap and enable cleared only after push
                                flags_reg[`FB_TRAP] <= 1'b0; // RULE18
                                flags_reg[`FB_IF] <= 1'b0; // RULE6
                                idx_reg <= 3'h0;
                                state_reg <= S_VEC; // RULE5
                            end else if (state_reg == S_VEC && idx_reg == 3'h3) begin
                                cs_reg <= {mem_rdata_in, byte_reg[2]};
                                ip_reg <= {byte_reg[1], byte_reg[0]};
                                state_reg <= S_CHECK;
                            end else if (state_reg == S_POP && idx_reg == 3'h5) begin
                                ip_reg <= {byte_reg[1], byte_reg[0]};
                                cs_reg <= {byte_reg[3], byte_reg[2]};
                                flags_reg <= {mem_rdata_in, byte_reg[4]}; // RULE8
                                sp_reg <= sp_reg + 16'h0006;
                                state_reg <= S_CHECK;
                            end else if (state_reg == S_ESC) begin
                                state_reg <= S_CHECK; // RULE15
                            end
                        end
                    end
                end
                S_CHECK: begin
                    if (step_pend_reg) begin
                        // Step trap runs after the instruction's own interrupt sequence, before handler
                        step_pend_reg <= 1'b0;
                        vtype_reg <= `VEC_STEP; // RULE17 RULE20
                        ret_ip_reg <= ip_reg;
                        idx_reg <= 3'h0;
                        state_reg <= S_PUSH;
                    end else begin
                        // Enable set now opens only after the next instruction
                        ie_shadow_reg <= busy_reg && op_reg == `OP_SET_INT_ENABLE; // RULE11
                        int_block_reg <= busy_reg && op_reg == `OP_WAIT; // RULE14
                        busy_reg <= 1'b0;
                        bus_lock_out <= 1'b0; // RULE16
                        qfill_reg <= 3'h0;
                        state_reg <= S_IDLE;
                    end
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end
endmodule // cpu_control_transfer_unit

//--- verif/ctu_assertions.sv
/* Port checker for the control transfer unit.
   Assumes binding onto the design top, one clock, clk_en_in held high. */
`timescale 1ns/1ps
module ctu_assertions (
    input wire ref_clk_in, // Clock
    input wire rstn_in, // Reset, active low
    input wire psel_in, // APB select
    input wire penable_in, // APB enable
    input wire [11:0] paddr_in, // APB address
    input wire pready_out, // APB ready
    input wire pslverr_out, // APB error
    input wire mem_req_out, // Memory request
    input wire mem_ack_in, // Memory done
    input wire [19:0] mem_addr_out, // Memory address
    input wire intr_ack_out, // Maskable taken
    input wire nmi_ack_out, // Non-maskable taken
    input wire test_in, // Wait release
    input wire waiting_out // Wait state
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);
    a_ready_pulse: assert property (pready_out |=> !pready_out) else $error("ready held");
    a_ready_bound: assert property (psel_in && penable_in |-> ##[0:2] pready_out)
        else $error("no ready");
    a_err_range: assert property (pready_out && paddr_in > 12'h020 |-> pslverr_out)
        else $error("no error");
    a_err_ready: assert property (pslverr_out |-> pready_out) else $error("stray error");
    a_mem_hold: assert property (mem_req_out && !mem_ack_in |=> mem_req_out
        && $stable(mem_addr_out)) else $error("request dropped");
    a_intr_pulse: assert property (intr_ack_out |=> !intr_ack_out) else $error("ack held");
    a_nmi_pulse: assert property (nmi_ack_out |=> !nmi_ack_out) else $error("nmi ack held");
    a_wait_exit: assert property (waiting_out && test_in |-> ##[1:3] !waiting_out)
        else $error("wait stuck");
endmodule // ctu_assertions
bind cpu_control_transfer_unit ctu_assertions chk (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
    .psel_in(psel_in), .penable_in(penable_in), .paddr_in(paddr_in), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .mem_req_out(mem_req_out), .mem_ack_in(mem_ack_in),
    .mem_addr_out(mem_addr_out), .intr_ack_out(intr_ack_out), .nmi_ack_out(nmi_ack_out),
    .test_in(test_in), .waiting_out(waiting_out));

//--- verif/ctu_mem_model.sv
/* Byte memory answering the unit's private port.
   Assumes one request at a time; only the low 1 KiB is decoded. */
`timescale 1ns/1ps
module ctu_mem_model (
    input wire clk_in, // Clock
    input wire req_in, // Request level
    input wire we_in, // Write
    input wire [19:0] addr_in, // Byte address
    input wire [7:0] wdata_in, // Write byte
    output logic [7:0] rdata_out, // Read byte
    output logic ack_out // Done pulse
);
    logic [7:0] mem [0:1023];
    logic [1:0] cnt = 2'h0;
    initial ack_out = 1'b0;
    initial rdata_out = 8'h00;
    initial for (int j = 0; j < 1024; j++) mem[j] = 8'h00;
    always @(posedge clk_in) begin
        ack_out <= 1'b0;
        rdata_out <= ~rdata_out; // Read byte is only valid with the ack
        if (req_in && !ack_out) begin
            cnt <= cnt + 2'h1;
            if (cnt == 2'h3) begin
                ack_out <= 1'b1;
                if (we_in) mem[addr_in[9:0]] <= wdata_in;
                else rdata_out <= mem[addr_in[9:0]];
            end
        end
    end
endmodule // ctu_mem_model

//--- verif/cpu_control_transfer_unit_tb.sv
/* Self-checking bench for the control transfer unit.
   Assumes the constants header and a byte memory model. */
`timescale 1ns/1ps
`include "ctu_consts.vh"
module cpu_control_transfer_unit_tb;
    logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, test = 0, nmi = 0, intr = 0, err;
    logic [11:0] pa = 0;
    logic [31:0] pwd = 0, q, c, e;
    wire [31:0] prd;
    wire prdy, perr, iack, nack, req, we, ack, lock, halt_instruction, wt;
    wire [19:0] ma;
    wire [7:0] mwd, mrd;
    int mismatches = 0, total_checks = 0, cycles = 0, n;
    cpu_control_transfer_unit dut (.ref_clk_in(clk), .rstn_in(rstn), .clk_en_in(1'b1),
        .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd),
        .prdata_out(prd), .pready_out(prdy), .pslverr_out(perr), .intr_in(intr),
        .intr_type_in(8'h00), .nmi_in(nmi), .test_in(test), .intr_ack_out(iack),
        .nmi_ack_out(nack), .mem_req_out(req), .mem_we_out(we), .mem_addr_out(ma),
        .mem_wdata_out(mwd), .mem_rdata_in(mrd), .mem_ack_in(ack), .bus_lock_out(lock),
        .halted_out(halt_instruction), .waiting_out(wt));
    ctu_mem_model mem0 (.clk_in(clk), .req_in(req), .we_in(we), .addr_in(ma),
        .wdata_in(mwd), .rdata_out(mrd), .ack_out(ack));
    initial forever #2 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin // Hang guard
            mismatches++;
            print_verdict();
        end
    end
    task check(input string nm, input logic [31:0] s, input logic [31:0] x);
        total_checks++;
        if (s !== x) begin
            mismatches++;
            $display("BAD %s exp %h seen %h", nm, x, s);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1; pen <= 0; pwr <= w; pa <= a; pwd <= d;
        @(posedge clk);
        pen <= 1;
        do begin @(posedge clk); end while (prdy !== 1'b1);
        q = prd; err = perr;
        psel <= 0; pen <= 0;
    endtask
    task idle();
        int k;
        k = 0;
        do begin apb(0, `A_STATUS, 0); k++; end while (q[3:0] !== 4'h0 && k < 60);
    endtask
    task run(input logic [4:0] op);
        apb(1, `A_CMD, {27'h0, op});
        idle();
    endtask
    task rd(input logic [11:0] a, input string nm, input logic [31:0] x);
        apb(0, a, 0);
        check(nm, q, x);
    endtask
    task s_loops();
        for (int i = 0; i < 16; i++) begin
            c = i[2] ? 32'h1 : 32'h0;
            apb(1, `A_FLAGS, {25'h0, i[3], 6'h02}); apb(1, `A_COUNT, c); apb(1, `A_IP, 32'h100);
            apb(1, `A_CMD, {19'h0, 8'h10, 5'(i[1:0] + 1)}); idle();
            e = (i[1:0] == 3) ? c : {16'h0, c[15:0] - 16'h1};
            n = (i[1:0] == 3) ? (c == 0) : (e != 0) && (i[1:0] == 0 || i[1:0] == 1 && i[3]
                || i[1:0] == 2 && !i[3]);
            rd(`A_COUNT, "count", e);
            rd(`A_IP, "ip", n ? 32'h111 : 32'h101);
        end
    endtask
    task s_flags();
        logic [4:0] ops [4] = '{`OP_SET_CARRY, `OP_FLIP_CARRY, `OP_FLIP_CARRY, `OP_CLEAR_CARRY};
        apb(1, `A_FLAGS, 32'h0402);
        for (int k = 0; k < 4; k++) begin
            run(ops[k]); apb(0, `A_FLAGS, 0);
            check("carry", q[0], k[0] ? 1'b0 : 1'b1);
        end
        run(`OP_CLEAR_DIR); apb(0, `A_FLAGS, 0); check("dir", q[10], 1'b0);
    endtask
    task s_int();
        mem0.mem[12] = 8'h34; mem0.mem[13] = 8'h12; mem0.mem[14] = 8'h00; mem0.mem[15] = 8'h00;
        apb(1, `A_FLAGS, 32'h0203); run(`OP_INT3);
        rd(`A_IP, "vec ip", 32'h1234);
        rd(`A_SP, "sp push", 32'h3FA);
        rd(`A_FLAGS, "int flags", 32'h0003);
        check("stk hi", mem0.mem[10'h3FF], 8'h02);
        check("stk lo", mem0.mem[10'h3FE], 8'h03);
        run(`OP_INT_RETURN);
        rd(`A_FLAGS, "ret flags", 32'h0203);
        rd(`A_SP, "sp pop", 32'h400);
        apb(1, `A_FLAGS, 32'h0002); run(`OP_INTO);
        rd(`A_SP, "into", 32'h400);
        apb(1, `A_FLAGS, 32'h0102); run(`OP_NOP);
        rd(`A_SP, "step sp", 32'h3FA);
        check("step img", mem0.mem[10'h3FF], 8'h01);
        rd(`A_FLAGS, "step tf", 32'h0002);
    endtask
    task s_halt_wait();
        apb(1, `A_CMD, {27'h0, `OP_HALT});
        n = 0; while (halt_instruction !== 1'b1 && n < 50) begin @(posedge clk); n++; end
        check("halt", halt_instruction, 1'b1);
        nmi <= 1;
        n = 0; while (halt_instruction !== 1'b0 && n < 50) begin @(posedge clk); n++; end
        check("halt exit", halt_instruction, 1'b0);
        nmi <= 0; idle();
        apb(1, `A_CMD, {27'h0, `OP_WAIT});
        n = 0; while (wt !== 1'b1 && n < 50) begin @(posedge clk); n++; end
        check("wait", wt, 1'b1);
        test <= 1; idle(); test <= 0;
        check("wait exit", wt, 1'b0);
        intr <= 1; apb(1, `A_CMD, 32'h2000 | `OP_NOP); @(posedge clk);
        check("lock", lock, 1'b1); idle();
        rd(`A_SP, "masked", 32'h3F4);
        apb(1, `A_FLAGS, 32'h0202); idle(); intr <= 0;
        rd(`A_SP, "unmasked", 32'h3EE);
    endtask
    task print_verdict();
        if (mismatches == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1;
        rd(`A_FLAGS, "flags rst", `FLAGS_RST);
        rd(`A_SP, "sp rst", `SP_RST);
        apb(0, 12'h024, 0); check("unmapped", err, 1'b1);
        s_loops(); s_flags(); s_int(); s_halt_wait();
        print_verdict();
    end
endmodule // cpu_control_transfer_unit_tb
